//--- inc/irq_agg_consts.vh
// Constants for the frontend interrupt aggregator: register map, field layout, bit positions
`ifndef IRQ_AGG_CONSTS_VH
`define IRQ_AGG_CONSTS_VH

// ----------------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------------
`define ADDR_W        8
`define IDX_W         6
`define DATA_W        32
`define STRB_W        4

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define IDX_ENABLE    6'h01
`define IDX_STATUS    6'h02
`define IDX_CLEAR     6'h03
`define IDX_BUS_STAT  6'h08
`define IDX_BUS_MASK  6'h09

// ----------------------------------------------------------------------
// Event flag layout
// ----------------------------------------------------------------------
`define EVT_W         20
`define EN_RW_W       17
`define EN_FIXED_W    3
`define EN_FIXED_ONES 3'h7
`define PAD_W         12
`define PAD_ZERO      12'h000
`define EVT_ZERO      20'h00000
`define EN_RW_RESET   17'h00000

`define BIT_LOW_POWER   19
`define BIT_NVM_FAIL    18
`define BIT_GEN_ERROR   17
`define BIT_TEMP        16
`define BIT_SUBCARRIER  15
`define BIT_FRAME_START 14
`define BIT_TIMER2      13
`define BIT_TIMER1      12
`define BIT_TIMER0      11
`define BIT_ACT_FAULT   10
`define BIT_OWN_ON      9
`define BIT_OWN_OFF     8
`define BIT_EXT_ON      7
`define BIT_EXT_OFF     6
`define BIT_STATE_CHG   5
`define BIT_CARD_ACT    4
`define BIT_MOD_FOUND   3
`define BIT_IDLE        2
`define BIT_TX_END      1
`define BIT_RX_END      0

// ----------------------------------------------------------------------
// Bus event status (read-to-clear) layout
// ----------------------------------------------------------------------
`define BUS_W         2
`define BUS_ZERO      2'h0
`define BUS_UNMAPPED  0
`define BUS_RO_WRITE  1
`define BUS_PAD_W     30
`define BUS_PAD_ZERO  30'h00000000

`define WORD_ZERO     32'h00000000

`endif

//--- rtl/nfc_frontend_irq_aggregator.v
// Interrupt aggregation of the contactless frontend with its APB register slave
//
// Summary of operation
// - Enable bits 16..0 are read/write, reset 0, and pass their flag to the pin.
// - Enable bits 19, 18, 17 are read-only ones; those events always reach the pin.
// - Read-only 32-bit status at index 2h; flags reset 0; bits 31..20 reserved zero.
// - Status 19 low-power detect, 18 nonvolatile program failure, 17 general error.
// - Bit 16 is the temperature event in status, enable and clear registers.
// - Bit 15 receive subcarrier seen, bit 14 receive frame start seen.
// - Bits 13, 12, 11 are expiries of timer 2, timer 1, timer 0.
// - Bit 10 is the active-communication RF fault, own enable and clear.
// - Bit 9 own field switched on in reader role, bit 8 switched off.
// - Bit 7 external field appeared, bit 6 external field vanished.
// - Bit 5 is a transceive state machine state change.
// - Bit 4 is activation while acting as an emulated card.
// - Bit 3 is detection of an external modulation scheme.
// - Bit 2 idle entered, bit 1 transmission done, bit 0 reception done.
// - Writing one to a bit of the clear register at index 3h resets that flag.
// - Clear bits 5..0 reset state-change, card, mode, idle, transmit and receive flags.
//
// The implementer's own choice: register access over APB.
`include "irq_agg_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module nfc_frontend_irq_aggregator (
  input  wire                 mclk,
  input  wire                 reset_n,
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [`ADDR_W-1:0]   paddr,
  input  wire [`DATA_W-1:0]   pwdata,
  input  wire [`STRB_W-1:0]   pstrb,
  output reg  [`DATA_W-1:0]   prdata,
  output reg                  pready,
  output reg                  pslverr,
  output reg                  irq_req,
  input  wire                 low_power_detect_event,
  input  wire                 nvm_program_fail_event,
  input  wire                 general_error_event,
  input  wire                 temperature_event,
  input  wire                 subcarrier_seen_event,
  input  wire                 frame_start_seen_event,
  input  wire                 third_timer_event,
  input  wire                 second_timer_event,
  input  wire                 first_timer_event,
  input  wire                 active_comm_fault_event,
  input  wire                 own_field_on_event,
  input  wire                 own_field_off_event,
  input  wire                 external_field_on_event,
  input  wire                 external_field_off_event,
  input  wire                 state_change_event,
  input  wire                 card_activated_event,
  input  wire                 modulation_found_event,
  input  wire                 idle_entered_event,
  input  wire                 transmit_done_event,
  input  wire                 receive_done_event
);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function [`ADDR_W-1:0] reg_addr;
    input [`IDX_W-1:0] idx;
    begin
      reg_addr = {idx, 2'b00};
    end
  endfunction

  function [`DATA_W-1:0] strb_mask;
    input [`STRB_W-1:0] strb;
    begin
      strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    end
  endfunction

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  reg  [`EVT_W-1:0]     flags;
  reg  [`EN_RW_W-1:0]   en_rw;
  reg  [`BUS_W-1:0]     bus_stat;
  reg  [`BUS_W-1:0]     bus_mask;

  reg  [`EVT_W-1:0]     next_flags;
  reg  [`EN_RW_W-1:0]   next_en_rw;
  reg  [`BUS_W-1:0]     next_bus_stat;
  reg  [`BUS_W-1:0]     next_bus_mask;
  reg  [`DATA_W-1:0]    next_prdata;

  wire [`EVT_W-1:0]     events;
  wire [`EVT_W-1:0]     en_eff;
  wire [`EVT_W-1:0]     next_en_eff;
  wire [`EVT_W-1:0]     clr_bits;
  wire [`DATA_W-1:0]    wbits;
  wire [`DATA_W-1:0]    wmask;
  wire [`BUS_W-1:0]     bus_events;
  wire [`BUS_W-1:0]     bus_rd_clear;

  // --------------------------------------------------------------------
  // Event vector assembly
  // --------------------------------------------------------------------
  assign events[`BIT_LOW_POWER]   = low_power_detect_event;
  assign events[`BIT_NVM_FAIL]    = nvm_program_fail_event;
  assign events[`BIT_GEN_ERROR]   = general_error_event;
  assign events[`BIT_TEMP]        = temperature_event;
  assign events[`BIT_SUBCARRIER]  = subcarrier_seen_event;
  assign events[`BIT_FRAME_START] = frame_start_seen_event;
  assign events[`BIT_TIMER2]      = third_timer_event;
  assign events[`BIT_TIMER1]      = second_timer_event;
  assign events[`BIT_TIMER0]      = first_timer_event;
  assign events[`BIT_ACT_FAULT]   = active_comm_fault_event;
  assign events[`BIT_OWN_ON]      = own_field_on_event;
  assign events[`BIT_OWN_OFF]     = own_field_off_event;
  assign events[`BIT_EXT_ON]      = external_field_on_event;
  assign events[`BIT_EXT_OFF]     = external_field_off_event;
  assign events[`BIT_STATE_CHG]   = state_change_event;
  assign events[`BIT_CARD_ACT]    = card_activated_event;
  assign events[`BIT_MOD_FOUND]   = modulation_found_event;
  assign events[`BIT_IDLE]        = idle_entered_event;
  assign events[`BIT_TX_END]      = transmit_done_event;
  assign events[`BIT_RX_END]      = receive_done_event;

  // --------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------
  // No wait state: read data is fetched in the setup cycle so every
  // slave output can come straight from a flop.
  wire setup   = psel & ~penable;
  wire access  = psel & penable & pready;
  wire hit_en  = (paddr == reg_addr(`IDX_ENABLE));
  wire hit_st  = (paddr == reg_addr(`IDX_STATUS));
  wire hit_clr = (paddr == reg_addr(`IDX_CLEAR));
  wire hit_bs  = (paddr == reg_addr(`IDX_BUS_STAT));
  wire hit_bm  = (paddr == reg_addr(`IDX_BUS_MASK));
  wire mapped  = hit_en | hit_st | hit_clr | hit_bs | hit_bm;
  wire wr_acc  = access & pwrite;

  assign wmask = strb_mask(pstrb);
  assign wbits = pwdata & wmask;

  assign en_eff      = {`EN_FIXED_ONES, en_rw};
  assign next_en_eff = {`EN_FIXED_ONES, next_en_rw};

  // Zero bits and bits above the event field are simply ignored
  assign clr_bits = (wr_acc & hit_clr) ? wbits[`EVT_W-1:0] : `EVT_ZERO;

  assign bus_events[`BUS_UNMAPPED] = access & ~mapped;
  assign bus_events[`BUS_RO_WRITE] = wr_acc & hit_st;

  // Only bits already returned to software are cleared, so an event
  // landing between fetch and completion survives the read
  assign bus_rd_clear = (access & ~pwrite & hit_bs) ? prdata[`BUS_W-1:0] : `BUS_ZERO;

  // --------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------
  always @* begin
    next_flags    = (flags & ~clr_bits) | events;
    next_bus_stat = (bus_stat & ~bus_rd_clear) | bus_events;
    next_en_rw    = en_rw;
    next_bus_mask = bus_mask;
    if (wr_acc & hit_en) begin
      next_en_rw = (en_rw & ~wmask[`EN_RW_W-1:0]) | wbits[`EN_RW_W-1:0];
    end
    if (wr_acc & hit_bm) begin
      next_bus_mask = (bus_mask & ~wmask[`BUS_W-1:0]) | wbits[`BUS_W-1:0];
    end
  end

  always @* begin
    next_prdata = `WORD_ZERO;
    if (setup & ~pwrite) begin
      if (hit_en) begin
        next_prdata = {`PAD_ZERO, en_eff};
      end else if (hit_st) begin
        next_prdata = {`PAD_ZERO, flags};
      end else if (hit_bs) begin
        next_prdata = {`BUS_PAD_ZERO, bus_stat};
      end else if (hit_bm) begin
        next_prdata = {`BUS_PAD_ZERO, bus_mask};
      end else begin
        next_prdata = `WORD_ZERO;
      end
    end
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      flags    <= `EVT_ZERO;
      en_rw    <= `EN_RW_RESET;
      bus_stat <= `BUS_ZERO;
      bus_mask <= `BUS_ZERO;
      prdata   <= `WORD_ZERO;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      irq_req  <= 1'b0;
    end else begin
      flags    <= next_flags;
      en_rw    <= next_en_rw;
      bus_stat <= next_bus_stat;
      bus_mask <= next_bus_mask;
      prdata   <= next_prdata;
      pready   <= setup;
      pslverr  <= setup & ~mapped;
      // Built from next values so the pin follows flags without lag
      irq_req  <= (|(next_flags & next_en_eff)) |
                  (|(next_bus_stat & next_bus_mask));
    end
  end

endmodule // nfc_frontend_irq_aggregator

`default_nettype wire

//--- dv/irq_agg_checker_sva.sv
// Checker watching the aggregator's register bus and interrupt pin
`timescale 1ns/1ps
`default_nettype none
module irq_agg_checker (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq_req,
  input wire logic        general_error_event
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire logic mapped = paddr inside {8'h04, 8'h08, 8'h0c, 8'h20, 8'h24};
  wire logic rd_acc = pready && !pwrite;
  property p_ready_setup;   psel && !penable |=> pready; endproperty
  property p_ready_pulse;   pready |=> !pready; endproperty
  property p_err_unmapped;  pready |-> (pslverr == !mapped); endproperty
  property p_rdata_idle;    !pready |-> prdata == 32'h0; endproperty
  property p_en_fixed;      rd_acc && paddr == 8'h04 |-> prdata[31:17] == 15'h7; endproperty
  property p_stat_reserved; rd_acc && paddr == 8'h08 |-> prdata[31:20] == 12'h0; endproperty
  property p_clear_read;    rd_acc && paddr == 8'h0c |-> prdata == 32'h0; endproperty
  property p_err_irq;       general_error_event |=> irq_req; endproperty
  property p_irq_hold;      irq_req && !psel |=> irq_req; endproperty
  a_ready_setup:   assert property (p_ready_setup) else $error("no ready after setup");
  a_ready_pulse:   assert property (p_ready_pulse) else $error("ready longer than one cycle");
  a_err_unmapped:  assert property (p_err_unmapped) else $error("slave error wrong");
  a_rdata_idle:    assert property (p_rdata_idle) else $error("read data outside access");
  a_en_fixed:      assert property (p_en_fixed) else $error("fixed enables wrong");
  a_stat_reserved: assert property (p_stat_reserved) else $error("status pad set");
  a_clear_read:    assert property (p_clear_read) else $error("clear reads nonzero");
  a_err_irq:       assert property (p_err_irq) else $error("error event no irq");
  a_irq_hold:      assert property (p_irq_hold) else $error("irq dropped unasked");
  c_slverr: cover property (pslverr);
  c_irq:    cover property ($rose(irq_req));
  c_status: cover property (rd_acc && paddr == 8'h08 && prdata != 32'h0);
endmodule // irq_agg_checker
bind nfc_frontend_irq_aggregator irq_agg_checker u_chk (.mclk(mclk), .reset_n(reset_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq_req(irq_req), .general_error_event(general_error_event));
`default_nettype wire

//--- dv/apb_host.sv
// Host model issuing single-word APB transfers
`timescale 1ns/1ps
`default_nettype none
module apb_host (
  input  wire logic        mclk,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [7:0]  paddr,
  output var  logic [31:0] pwdata,
  output var  logic [3:0]  pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
  // Request held until ready; on release address and write data show the inverse so stale data is never reused
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge mclk);
    penable <= 1'b1;
    // Ready is judged on its value before the edge's own updates land, so the
    // sampling edge is never missed when the slave drops ready at that edge
    @(posedge mclk iff pready);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge mclk);
  endtask
endmodule // apb_host
`default_nettype wire

//--- dv/tb_nfc_frontend_irq_aggregator.sv
// Self-checking bench for the interrupt aggregator
`timescale 1ns/1ps
`default_nettype none
module tb_nfc_frontend_irq_aggregator;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic [19:0] ev = 20'h0;
  logic        psel, penable, pwrite, pready, pslverr, irq_req, er;
  logic [7:0]  paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, rd;
  int          miscompares = 0, n_tests = 0, cyc = 0;
  always #25 mclk = ~mclk;
  apb_host host (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  nfc_frontend_irq_aggregator dut (.mclk(mclk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_req(irq_req),
    .low_power_detect_event(ev[19]), .nvm_program_fail_event(ev[18]),
    .general_error_event(ev[17]), .temperature_event(ev[16]), .subcarrier_seen_event(ev[15]),
    .frame_start_seen_event(ev[14]), .third_timer_event(ev[13]), .second_timer_event(ev[12]),
    .first_timer_event(ev[11]), .active_comm_fault_event(ev[10]), .own_field_on_event(ev[9]),
    .own_field_off_event(ev[8]), .external_field_on_event(ev[7]),
    .external_field_off_event(ev[6]), .state_change_event(ev[5]), .card_activated_event(ev[4]),
    .modulation_found_event(ev[3]), .idle_entered_event(ev[2]), .transmit_done_event(ev[1]),
    .receive_done_event(ev[0]));
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd, er);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h0, rd, er);
    chk(rd, exp);
  endtask
  task automatic t_regs();
    rd_chk(8'h04, 32'h000e0000);
    rd_chk(8'h08, 32'h0);
    wr(8'h04, 32'hffffffff);
    rd_chk(8'h04, 32'h000fffff);
    wr(8'h04, 32'h0);
  endtask
  // Walks every source: latch, mask and enable (bits 16..0 only), clear
  task automatic t_events();
    for (int i = 0; i < 20; i++) begin
      ev <= 20'h1 << i;
      @(posedge mclk);
      ev <= 20'h0;
      @(posedge mclk);
      chk({31'h0, irq_req}, {31'h0, i >= 17});
      wr(8'h0c, 32'h0);
      rd_chk(8'h08, 32'h1 << i);
      if (i < 17) wr(8'h04, 32'h1 << i);
      chk({31'h0, irq_req}, 32'h1);
      wr(8'h0c, 32'h1 << i);
      chk({31'h0, irq_req}, 32'h0);
      rd_chk(8'h08, 32'h0);
      wr(8'h04, 32'h0);
    end
  endtask
  task automatic t_coincide();
    ev <= 20'h00020;
    wr(8'h0c, 32'h20);
    ev <= 20'h0;
    rd_chk(8'h08, 32'h20);
    wr(8'h0c, 32'h20);
  endtask
  task automatic t_bus_irq();
    host.xfer(1'b0, 8'h40, 32'h0, rd, er);
    chk({er, rd[30:0]}, 32'h80000000);
    wr(8'h08, 32'hffffffff);
    rd_chk(8'h08, 32'h0);
    wr(8'h24, 32'h3);
    chk({31'h0, irq_req}, 32'h1);
    rd_chk(8'h20, 32'h3);
    chk({31'h0, irq_req}, 32'h0);
    wr(8'h24, 32'h0);
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 4000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_events();
    t_coincide();
    t_bus_irq();
    conclude();
  end
endmodule // tb_nfc_frontend_irq_aggregator
`default_nettype wire
